/* rtl/csi_tim_regs.sv */
// csi-2 d-phy transmit timing override registers behind apb
// assumes one clock pclk; the phy timing generator reads the value ports
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module csi_tim_regs
   import csi_tim_pkg::*;
(
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   // apb answer
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // timing to the phy
   output logic [2:0] lane_rate,
   output logic hs_trail_override_en,
   output logic [6:0] hs_trail_value,
   output logic hs_exit_override_en,
   output logic [6:0] hs_exit_value,
   output logic plx_override_en,
   output logic [6:0] plx_value
);

   // ==========================================
   // address decode
   logic [7:0] idx;
   logic mapped;
   logic setup;
   logic acc_wr;
   logic [NUM_ENT-1:0] ent_hit;
   logic rate_hit;
   logic [NUM_ENT-1:0] hit_wr;

   assign idx = paddr[9:2];
   assign setup = psel && !penable;
   assign acc_wr = psel && penable && pwrite && pstrb[0];
   assign rate_hit = (idx == IDX_RATE_CFG);

   // valid only on word aligned, in-range addresses
   always_comb begin
      mapped = rate_hit;
      if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
         mapped = 1'b0;
      end else begin
         mapped = rate_hit || (ent_hit != '0);
      end
   end

   // ==========================================
   // lane rate select
   rate_t rate_q;

   // unsupported codes are dropped, rate keeps its value
   // a bad code keeps the old rate so the derived tables are never indexed past the end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_q <= RATE_RST;
      end else if (acc_wr && mapped && rate_hit) begin
         if (pwdata[RATE_MSB:0] < rate_t'(NUM_RATES)) begin
            rate_q <= pwdata[RATE_MSB:0];
         end
      end
   end

   assign lane_rate = rate_q;

   // ==========================================
   // automatically derived values
   logic [6:0] auto_val [NUM_ENT];

   // timing entries follow the rate, reserved ones their default
   always_comb begin
      for (int k = 0; k < NUM_ENT; k++) begin
         auto_val[k] = ENT_RST[k];
      end
      auto_val[0] = TRAIL_TBL[rate_q];
      auto_val[1] = EXIT_TBL[rate_q];
      auto_val[2] = PLX_TBL[rate_q];
   end

   // ==========================================
   // override bit and value field per entry
   logic ov_q [NUM_ENT];
   logic [6:0] fld_q [NUM_ENT];

   genvar g;
   generate
      for (g = 0; g < NUM_ENT; g++) begin : g_ent
         assign ent_hit[g] = (idx == ENT_IDX[g]);
         assign hit_wr[g] = acc_wr && mapped && ent_hit[g];

         // top bit is plain read/write
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ov_q[g] <= OV_RST;
            end else if (hit_wr[g]) begin
               ov_q[g] <= pwdata[OV_BIT];
            end
         end

         // field tracks auto value until override, then holds writes
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               fld_q[g] <= ENT_RST[g];
            end else if (!ov_q[g]) begin
               fld_q[g] <= auto_val[g];
            end else if (hit_wr[g]) begin
               fld_q[g] <= pwdata[FLD_MSB:0];
            end
         end
      end
   endgenerate

   // effective values handed to the phy timing generator
   assign hs_trail_override_en = ov_q[0];
   assign hs_trail_value = fld_q[0];
   assign hs_exit_override_en = ov_q[1];
   assign hs_exit_value = fld_q[1];
   assign plx_override_en = ov_q[2];
   assign plx_value = fld_q[2];

   // ==========================================
   // read data and error, captured in the setup cycle
   logic [31:0] rd_d;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // select the addressed register, upper bits read zero
   always_comb begin
      rd_d = 32'h0000_0000;
      if (rate_hit) begin
         rd_d[RATE_MSB:0] = rate_q;
      end
      for (int k = 0; k < NUM_ENT; k++) begin
         if (ent_hit[k]) begin
            rd_d[7:0] = {ov_q[k], fld_q[k]};
         end
      end
      if (!mapped) begin
         rd_d = 32'h0000_0000;
      end
   end

   // answer is ready in the access cycle that follows setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
         pslverr_q <= !mapped;
      end
   end

   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q && psel && penable;

   // ==========================================
   // assertions
   // all properties sample on pclk and stay quiet while presetn is low
   // field values lag the derived value by one cycle, hence the |=> forms
   property p_trail_auto;
      @(posedge pclk) disable iff (!presetn)
      !ov_q[0] |=> hs_trail_value == $past(auto_val[0]);
   endproperty
   a_trail_auto: assert property (p_trail_auto)
      else $error("trail value did not follow derived value");

   property p_trail_ovr_wr;
      @(posedge pclk) disable iff (!presetn)
      ov_q[0] && hit_wr[0] |=> hs_trail_value == $past(pwdata[6:0]);
   endproperty
   a_trail_ovr_wr: assert property (p_trail_ovr_wr)
      else $error("trail write under override not stored");

   property p_trail_hold;
      @(posedge pclk) disable iff (!presetn)
      ov_q[0] && !hit_wr[0] |=> $stable(hs_trail_value);
   endproperty
   a_trail_hold: assert property (p_trail_hold)
      else $error("overridden trail value changed");

   property p_exit_ovr_wr;
      @(posedge pclk) disable iff (!presetn)
      ov_q[1] && hit_wr[1] |=> hs_exit_value == $past(pwdata[6:0]);
   endproperty
   a_exit_ovr_wr: assert property (p_exit_ovr_wr)
      else $error("exit write under override not stored");

   property p_exit_ro;
      @(posedge pclk) disable iff (!presetn)
      !ov_q[1] && hit_wr[1] |=> hs_exit_value == $past(auto_val[1]);
   endproperty
   a_exit_ro: assert property (p_exit_ro)
      else $error("exit write taken while automatic");

   property p_plx_ovr_wr;
      @(posedge pclk) disable iff (!presetn)
      ov_q[2] && hit_wr[2] |=> plx_value == $past(pwdata[6:0]);
   endproperty
   a_plx_ovr_wr: assert property (p_plx_ovr_wr)
      else $error("plx write under override not stored");

   property p_plx_ro;
      @(posedge pclk) disable iff (!presetn)
      !ov_q[2] && hit_wr[2] |=> plx_value == $past(auto_val[2]);
   endproperty
   a_plx_ro: assert property (p_plx_ro)
      else $error("plx write taken while automatic");

   property p_rate_follow;
      @(posedge pclk) disable iff (!presetn)
      $changed(rate_q) && rate_q == RATE_1600 && !ov_q[1]
      |=> hs_exit_value == EXIT_TBL[4];
   endproperty
   a_rate_follow: assert property (p_rate_follow)
      else $error("exit value did not follow new lane rate");

   property p_rsvd_read;
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && paddr == {2'b00, IDX_RSVD_A, 2'b00} && !ov_q[3]
      |=> psel && penable ##0 prdata[7:0] == {1'b0, ENT_RST[3]};
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("reserved register read not its default");

   property p_rsvd_top;
      @(posedge pclk) disable iff (!presetn)
      hit_wr[11] |=> ov_q[11] == $past(pwdata[7]);
   endproperty
   a_rsvd_top: assert property (p_rsvd_top)
      else $error("reserved top bit write lost");

   property p_unmapped_err;
      @(posedge pclk) disable iff (!presetn)
      setup && !mapped |=> (psel && penable) |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped access not flagged");

   property p_trail_ro;
      @(posedge pclk) disable iff (!presetn)
      !ov_q[0] && hit_wr[0] |=> hs_trail_value == $past(auto_val[0]);
   endproperty
   a_trail_ro: assert property (p_trail_ro)
      else $error("trail write taken while automatic");

   property p_exit_auto;
      @(posedge pclk) disable iff (!presetn)
      !ov_q[1] |=> hs_exit_value == $past(auto_val[1]);
   endproperty
   a_exit_auto: assert property (p_exit_auto)
      else $error("exit value did not follow derived value");

   property p_exit_hold;
      @(posedge pclk) disable iff (!presetn)
      ov_q[1] && !hit_wr[1] |=> $stable(hs_exit_value);
   endproperty
   a_exit_hold: assert property (p_exit_hold)
      else $error("overridden exit value changed");

   property p_plx_auto;
      @(posedge pclk) disable iff (!presetn)
      !ov_q[2] |=> plx_value == $past(auto_val[2]);
   endproperty
   a_plx_auto: assert property (p_plx_auto)
      else $error("plx value did not follow derived value");

   property p_plx_hold;
      @(posedge pclk) disable iff (!presetn)
      ov_q[2] && !hit_wr[2] |=> $stable(plx_value);
   endproperty
   a_plx_hold: assert property (p_plx_hold)
      else $error("overridden plx value changed");

   property p_rate_bad;
      @(posedge pclk) disable iff (!presetn)
      acc_wr && mapped && rate_hit && pwdata[RATE_MSB:0] > RATE_1600
      |=> $stable(rate_q);
   endproperty
   a_rate_bad: assert property (p_rate_bad)
      else $error("unsupported lane rate code taken");

   property p_plx_rate;
      @(posedge pclk) disable iff (!presetn)
      $changed(rate_q) && rate_q == RATE_400 && !ov_q[2]
      |=> plx_value == PLX_TBL[0];
   endproperty
   a_plx_rate: assert property (p_plx_rate)
      else $error("plx value did not follow new lane rate");

   property p_rsvd_ro;
      @(posedge pclk) disable iff (!presetn)
      !ov_q[3] && hit_wr[3] |=> fld_q[3] == ENT_RST[3];
   endproperty
   a_rsvd_ro: assert property (p_rsvd_ro)
      else $error("reserved field write taken while top bit clear");

   property p_rsvd_hold;
      @(posedge pclk) disable iff (!presetn)
      ov_q[3] && !hit_wr[3] |=> $stable(fld_q[3]);
   endproperty
   a_rsvd_hold: assert property (p_rsvd_hold)
      else $error("reserved field changed without a write");

   property p_rd_upper;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("read data upper bits not zero");

   // ==========================================
   // scenario coverage
   // main scenarios: override write, rate change, bad address, reserved write
   c_trail_ovr: cover property (@(posedge pclk) disable iff (!presetn)
      ov_q[0] && hit_wr[0]);
   c_rate_chg: cover property (@(posedge pclk) disable iff (!presetn)
      $changed(rate_q) && !ov_q[2]);
   c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
      pslverr);
   c_rsvd_wr: cover property (@(posedge pclk) disable iff (!presetn)
      hit_wr[3] && ov_q[3]);

endmodule : csi_tim_regs

/* rtl/csi_tim_pkg.sv */
// csi-2 transmit timing override register constants
// assumes an apb slave with 32-bit data and one word per register
package csi_tim_pkg;
   // ==========================================
   // register indices (byte address = 4 * index)
   localparam int NUM_ENT = 12;
   localparam logic [7:0] IDX_HS_TRAIL = 8'h46;
   localparam logic [7:0] IDX_HS_EXIT = 8'h47;
   localparam logic [7:0] IDX_PLX = 8'h48;
   localparam logic [7:0] IDX_RSVD_A = 8'h60;
   localparam logic [7:0] IDX_RSVD_I = 8'h68;
   localparam logic [7:0] IDX_RATE_CFG = 8'h70;
   localparam logic [7:0] ENT_IDX [NUM_ENT] = '{
      8'h46, 8'h47, 8'h48, 8'h60, 8'h61, 8'h62,
      8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68};
   // ==========================================
   // field layout
   localparam int OV_BIT = 7;
   localparam int FLD_MSB = 6;
   localparam int RATE_MSB = 2;
   // ==========================================
   // reset values of the 7-bit value fields
   localparam logic [6:0] ENT_RST [NUM_ENT] = '{
      7'h08, 7'h0b, 7'h06, 7'h05, 7'h1b, 7'h0b,
      7'h0a, 7'h06, 7'h0c, 7'h08, 7'h0b, 7'h06};
   localparam logic OV_RST = 1'b0;
   // ==========================================
   // output lane rate codes
   typedef logic [2:0] rate_t;
   localparam rate_t RATE_400 = 3'h0;
   localparam rate_t RATE_800 = 3'h1;
   localparam rate_t RATE_1200 = 3'h2;
   localparam rate_t RATE_1500 = 3'h3;
   localparam rate_t RATE_1600 = 3'h4;
   localparam rate_t RATE_RST = RATE_800;
   localparam int NUM_RATES = 5;
   // ==========================================
   // derived timing per rate code, 800 Mbps entry equals reset value
   localparam logic [6:0] TRAIL_TBL [NUM_RATES] = '{
      7'h05, 7'h08, 7'h0b, 7'h0d, 7'h0e};
   localparam logic [6:0] EXIT_TBL [NUM_RATES] = '{
      7'h06, 7'h0b, 7'h10, 7'h14, 7'h15};
   localparam logic [6:0] PLX_TBL [NUM_RATES] = '{
      7'h04, 7'h06, 7'h08, 7'h0a, 7'h0b};
endpackage : csi_tim_pkg

/* tb/tb.sv */
// self-checking bench for the timing override registers
// assumes csi_tim_pkg and csi_tim_regs compiled first; drives apb directly
`timescale 1ns/1ps
module tb
   import csi_tim_pkg::*;
;
   // ==========================================
   // signals
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [3:0] pstrb = '0;
   logic pready, pslverr, hs_trail_override_en, hs_exit_override_en, plx_override_en;
   logic [31:0] prdata, rd;
   logic [2:0] lane_rate;
   logic [6:0] hs_trail_value, hs_exit_value, plx_value;
   logic er;
   int fail_count = 0, compares = 0;
   typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] exp; logic err;} row_t;
   row_t rows [15];
   logic [11:0] ta [3] = '{12'h118, 12'h11c, 12'h120};
   // ==========================================
   // clock and design
   always #50 pclk = ~pclk;
   csi_tim_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .lane_rate(lane_rate),
      .hs_trail_override_en(hs_trail_override_en), .hs_trail_value(hs_trail_value),
      .hs_exit_override_en(hs_exit_override_en), .hs_exit_value(hs_exit_value),
      .plx_override_en(plx_override_en), .plx_value(plx_value));
   // ==========================================
   // helpers
   task automatic report_and_stop();
      $display("tests done: %0d compares, %0d mismatches", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         fail_count++;
         report_and_stop();
      end
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d, 4'hf, rd, er);
   endtask : wr
   task automatic settle();
      repeat (2) @(posedge pclk);
      #1;
   endtask : settle
   // ==========================================
   // main sequence
   initial begin
      for (int i = 0; i < NUM_ENT; i++) rows[i] = '{0, {2'b00, ENT_IDX[i], 2'b00}, 0, ENT_RST[i], 0};
      rows[12] = '{1, 12'h118, 32'h2a, 0, 0};
      rows[13] = '{0, 12'h1fc, 0, 0, 1};
      rows[14] = '{0, 12'h119, 0, 0, 1};
      repeat (8) @(posedge pclk);
      presetn <= 1;
      // table rows: reset values, ignored field write, unmapped places
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d, 4'hf, rd, er);
         if (!rows[i].wr) chk("row rdata", rows[i].exp, rd);
         chk("row err", {31'h0, rows[i].err}, {31'h0, er});
      end
      apb(0, 12'h118, 0, 4'hf, rd, er);
      chk("trail after ignored write", 32'h08, rd);
      $display("test rows done");
      // derived values follow every lane rate; bad code ignored
      for (int r = 0; r < NUM_RATES; r++) begin
         wr(12'h1c0, r);
         settle();
         chk("lane_rate", r, lane_rate);
         foreach (ta[i]) begin
            apb(0, ta[i], 0, 4'hf, rd, er);
            chk("auto value", i == 0 ? TRAIL_TBL[r] : i == 1 ? EXIT_TBL[r] : PLX_TBL[r], rd);
         end
      end
      wr(12'h1c0, 5);
      settle();
      chk("lane_rate bad code", 4, lane_rate);
      $display("test rates done");
      // override: set bit first, then program the value
      foreach (ta[i]) begin
         wr(ta[i], 32'h80);
         wr(ta[i], 32'hb0 + i);
         apb(0, ta[i], 0, 4'hf, rd, er);
         chk("override readback", 32'hb0 + i, rd);
      end
      wr(12'h1c0, 0);
      settle();
      chk("trail out", 7'h30, hs_trail_value);
      chk("exit out", 7'h31, hs_exit_value);
      chk("plx out", 7'h32, plx_value);
      chk("ov bits", 3'h7, {hs_trail_override_en, hs_exit_override_en, plx_override_en});
      wr(12'h11c, 32'h00);
      settle();
      chk("exit back to auto", EXIT_TBL[0], hs_exit_value);
      apb(1, 12'h120, 32'h85, 4'h0, rd, er);
      apb(0, 12'h120, 0, 4'hf, rd, er);
      chk("plx no strobe", 32'hb2, rd);
      $display("test override done");
      // reserved top bit is read/write
      wr(12'h180, 32'h80);
      apb(0, 12'h180, 0, 4'hf, rd, er);
      chk("reserved a", 32'h85, rd);
      wr(12'h180, 32'h05);
      apb(0, 12'h180, 0, 4'hf, rd, er);
      chk("reserved a restored", 32'h05, rd);
      wr(12'h1a0, 32'h80);
      apb(0, 12'h1a0, 0, 4'hf, rd, er);
      chk("reserved i", 32'h86, rd);
      wr(12'h1a0, 32'h06);
      apb(0, 12'h1a0, 0, 4'hf, rd, er);
      chk("reserved i restored", 32'h06, rd);
      $display("test reserved done");
      // reset in mid-run restores defaults
      @(posedge pclk);
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      chk("rate after reset", RATE_800, lane_rate);
      chk("trail after reset", 8'h08, {hs_trail_override_en, hs_trail_value});
      chk("exit after reset", 8'h0b, {hs_exit_override_en, hs_exit_value});
      chk("plx after reset out", 8'h06, {plx_override_en, plx_value});
      apb(0, 12'h120, 0, 4'hf, rd, er);
      chk("plx after reset", 32'h06, rd);
      $display("test reset done");
      report_and_stop();
   end
endmodule : tb
